// >>> verilog/clk_power_consts.svh
// Register offsets, field positions, reset values and counts for the clock and power block.
// Assumes inclusion by bare name from the package and the test files.
`ifndef CLK_POWER_CONSTS_SVH
`define CLK_POWER_CONSTS_SVH

// Avalon byte addresses of the registers, one aligned word each.
`define OFS_SYS_CLK_CTRL 6'h00
`define OFS_OSC_CTRL 6'h04
`define OFS_LOW_SPEED_CTRL 6'h08
`define OFS_CLK_DIV_CTRL 6'h0c
`define OFS_PERIPH_CLK_CTRL 6'h10
`define OFS_PLL_CTRL_ONE 6'h14
`define OFS_PLL_STATUS 6'h18
`define OFS_PROTECT_CTRL 6'h1c
`define OFS_PROTECT_CTRL_TWO 6'h20
`define OFS_LVD_CTRL 6'h24
`define OFS_POWER_CTRL 6'h28

// Field positions.
`define BIT_CLKPIN_LO 0
`define BIT_CLKPIN_HI 1
`define BIT_WAIT_PSTOP 2
`define BIT_MAIN_OSC_STOP 5
`define BIT_DETECT_EN 0
`define BIT_OSC_STOP_FLAG 1
`define BIT_BCS 4
`define BIT_EVEN_SRC_MAIN 6
`define BIT_CLK_UNLOCK 0
`define BIT_DIV_UNLOCK 7
`define BIT_CMD_WAIT 0
`define BIT_CMD_STOP 1
`define BIT_KEEP_SUB 4

// Clock output pin selections.
`define CLKPIN_OFF 2'h0
`define CLKPIN_LOW_SPEED 2'h1
`define CLKPIN_DIV8 2'h2
`define CLKPIN_DIV32 2'h3

// Fixed divide ratios and reset values.
`define RATIO_DIV8 8'h08
`define RATIO_DIV32 8'h20
`define RST_BYTE 8'h00
`define PLL_STATUS_W 16

`endif

// >>> verilog/clk_power_pkg.sv
// Types shared by the clock and power control block.
// Assumes the constants header sits beside it.
package clk_power_pkg;
  `include "clk_power_consts.svh"

  // Power states, one-hot.
  typedef enum logic [2:0]
  {
    PWR_NORMAL = 3'b001,
    PWR_WAIT = 3'b010,
    PWR_STOP = 3'b100
  } power_state_t;

  // One-cycle enable pulses standing for the derived clocks.
  typedef struct packed
  {
    logic cpu;
    logic periph_bus;
    logic periph_clock_div1;
    logic periph_clock_div8;
    logic periph_clock_div32;
    logic converter_clock;
    logic even_divided_periph_clock;
    logic sub_clock_div32;
  } clk_ticks_t;

  // Wake sources seen by the power controller.
  typedef struct packed
  {
    logic nmi;
    logic lvd_irq;
    logic [63:0] periph_irq;
    logic [2:0] ext_irq_six_to_eight;
  } wake_src_t;
endpackage

// >>> verilog/tick_divider.sv
// Enable-pulse divider: passes one of every ratio source pulses.
// Assumes the source pulse is synchronous to clk; ratio 0 or 1 passes every pulse.
`timescale 1ns/1ps
module tick_divider #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Source pulse, ratio and run gate.
  input wire logic tick_in,
  input wire logic [W-1:0] ratio,
  input wire logic run,
  // Divided pulse.
  output logic tick_out
);
  logic [W-1:0] cnt_q;
  logic last;

  // The count wraps when it reaches one less than the ratio.
  assign last = ({1'b0, cnt_q} + {{W{1'b0}}, 1'b1}) >= {1'b0, ratio};
  assign tick_out = run && tick_in && last;

  // Stopping the divider clears it, so a restart begins a whole period.
  always_ff @(posedge clk)
  begin
    if (sys_rst || !run)
      cnt_q <= '0;
    else if (tick_in)
      cnt_q <= last ? '0 : cnt_q + {{(W-1){1'b0}}, 1'b1};
  end
endmodule // tick_divider

// >>> verilog/power_mode_fsm.sv
// Power mode state machine with its wake decision.
// Assumes wake sources are synchronous and already level-masked by the interrupt controller.
`timescale 1ns/1ps
module power_mode_fsm
  import clk_power_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Mode commands from software, one-cycle pulses.
  input wire logic enter_wait,
  input wire logic enter_stop,
  // Wake sources and routing.
  input wire wake_src_t src,
  input wire logic lvd_enable,
  input wire logic [2:0] iio_route,
  // Current state.
  output power_state_t state
);
  power_state_t state_q;
  logic [2:0] ext_prev_q;
  logic ext_wake;
  logic wait_wake;
  logic stop_wake;

  // External inputs six to eight wake only on a falling edge and only when routed.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ext_prev_q <= 3'h0;
    else
      ext_prev_q <= src.ext_irq_six_to_eight;
  end
  assign ext_wake = |(ext_prev_q & ~src.ext_irq_six_to_eight & iio_route);

  assign wait_wake = src.nmi || (|src.periph_irq) || ext_wake;
  assign stop_wake = wait_wake || (src.lvd_irq && lvd_enable);

  // Reset always lands in normal; any other wake returns there too.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_q <= PWR_NORMAL;
    else
      case (state_q)
        PWR_NORMAL:
          if (enter_stop)
            state_q <= PWR_STOP;
          else if (enter_wait)
            state_q <= PWR_WAIT;
        PWR_WAIT:
          if (wait_wake)
            state_q <= PWR_NORMAL;
        PWR_STOP:
          if (stop_wake)
            state_q <= PWR_NORMAL;
        default:
          state_q <= PWR_NORMAL;
      endcase
  end
  assign state = state_q;
endmodule // power_mode_fsm

// >>> verilog/clock_power_ctrl.sv
// Clock generation and power mode control with an Avalon-MM register slave.
// Assumes clk is the PLL clock, low speed clocks arrive as enable pulses, inputs are synchronous.
//
// What this block does
// - Clock pin select 01 outputs low speed clock.
// - Oscillator stop flag sets when main clock stops.
// - Detect enable bit gates the osc_stop_detected output; the stop flag sets regardless.
// - Free-run bit picks lock-in or self-oscillation.
// - Self-oscillation status resets on set, holds when stopped.
// - Three power states: normal, wait, stop.
// - Wait exits on reset, NMI, peripheral interrupts.
// - Wait clock stop bit halts peripheral-source clocks.
// - Bit clear keeps peripheral-source clocks in wait.
// - Independent clocks keep running in wait.
// - Wake resumes on the clock used before wait.
// - External inputs six to eight wake via routed path.
// - Stop mode halts all but protected clocks.
// - Detector enable bit; software waits settling time.
// - Stop exits on reset, NMI, voltage, peripheral interrupts.
`timescale 1ns/1ps
module clock_power_ctrl
  import clk_power_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM register slave.
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Oscillator and low speed clock inputs.
  input wire logic main_osc_running,
  input wire logic pll_running,
  input wire logic sub_clock_tick,
  input wire logic onchip_low_tick,
  // Wake sources.
  input wire wake_src_t wake_in,
  // Derived clock enables and pins.
  output clk_ticks_t ticks_q,
  output logic clock_output_pin,
  output logic main_osc_enable,
  output logic pll_free_run_out,
  output logic osc_stop_detected,
  output logic low_voltage_detect_on,
  output logic wait_mode,
  output logic stop_mode
);
  // Software-visible register bits, plus the internal edge, bus and pin registers.
  logic [1:0] clkpin_select_q;
  logic wait_periph_clock_stop_q;
  logic main_osc_stop_q;
  logic osc_stop_detect_enable_q;
  logic pll_osc_stop_flag_q;
  logic [1:0] low_speed_select_q;
  logic [1:0] base_divide_q;
  logic [1:0] pbus_divide_q;
  logic clock_source_select_q;
  logic [1:0] periph_divide_q;
  logic [3:0] even_n_q;
  logic even_src_main_q;
  logic pll_free_run_q;
  logic pll_free_run_prev_q;
  logic [`PLL_STATUS_W-1:0] pll_status_q;
  logic clock_write_unlock_q;
  logic divider_write_unlock_q;
  logic low_voltage_detect_enable_q;
  logic keep_sub_in_stop_q;
  logic [2:0] iio_route_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic clock_output_pin_q;

  // Bus decode and power state wires.
  logic wr_en;
  logic [7:0] wb;
  logic cmd_wait;
  logic cmd_stop;
  power_state_t state;
  logic is_normal;
  logic is_wait;
  logic is_stop;

  // Derived clock wires.
  logic low_speed_tick;
  logic base_src_tick;
  logic base_tick;
  logic pbus_tick;
  logic psrc_tick;
  logic div8_tick;
  logic div32_tick;
  logic even_tick;
  logic sub32_tick;
  logic psrc_run;
  logic even_run;
  logic sub_run;
  logic osc_stopped;
  logic [7:0] even_ratio;
  logic clkpin_tick;

  // A write takes effect only at the edge where waitrequest is low.
  assign wr_en = write && !ack_q && byteenable[0];
  assign wb = writedata[7:0];
  assign cmd_wait = wr_en && (address == `OFS_POWER_CTRL) && wb[`BIT_CMD_WAIT];
  assign cmd_stop = wr_en && (address == `OFS_POWER_CTRL) && wb[`BIT_CMD_STOP];

  // Waitrequest is high by default and drops for exactly one cycle per request.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ack_q <= 1'b1;
    else if ((read || write) && ack_q)
      ack_q <= 1'b0;
    else
      ack_q <= 1'b1;
  end
  assign waitrequest = ack_q;

  // Read data is captured while waitrequest is high and stands at the answer edge.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else if (read && ack_q)
      case (address)
        `OFS_SYS_CLK_CTRL:
          rdata_q <= {26'h0, main_osc_stop_q, 2'h0, wait_periph_clock_stop_q, clkpin_select_q};
        `OFS_OSC_CTRL:
          rdata_q <= {30'h0, pll_osc_stop_flag_q, osc_stop_detect_enable_q};
        `OFS_LOW_SPEED_CTRL:
          rdata_q <= {30'h0, low_speed_select_q};
        `OFS_CLK_DIV_CTRL:
          rdata_q <= {27'h0, clock_source_select_q, pbus_divide_q, base_divide_q};
        `OFS_PERIPH_CLK_CTRL:
          rdata_q <= {25'h0, even_src_main_q, even_n_q, periph_divide_q};
        `OFS_PLL_CTRL_ONE:
          rdata_q <= {31'h0, pll_free_run_q};
        `OFS_PLL_STATUS:
          rdata_q <= {16'h0, pll_status_q};
        `OFS_PROTECT_CTRL:
          rdata_q <= {31'h0, clock_write_unlock_q};
        `OFS_PROTECT_CTRL_TWO:
          rdata_q <= {24'h0, divider_write_unlock_q, 7'h0};
        `OFS_LVD_CTRL:
          rdata_q <= {31'h0, low_voltage_detect_enable_q};
        `OFS_POWER_CTRL:
          rdata_q <= {24'h0, iio_route_q, keep_sub_in_stop_q, 1'b0, state};
        default:
          rdata_q <= 32'h0000_0000;
      endcase
  end
  assign readdata = rdata_q;

  // Protect registers hold the unlock bits that guard the clock registers.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      clock_write_unlock_q <= 1'b0;
      divider_write_unlock_q <= 1'b0;
    end
    else
    begin
      if (wr_en && address == `OFS_PROTECT_CTRL)
        clock_write_unlock_q <= wb[`BIT_CLK_UNLOCK];
      if (wr_en && address == `OFS_PROTECT_CTRL_TWO)
        divider_write_unlock_q <= wb[`BIT_DIV_UNLOCK];
    end
  end

  // System and peripheral clock control; locked writes are dropped silently.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      clkpin_select_q <= 2'h0;
      wait_periph_clock_stop_q <= 1'b0;
      main_osc_stop_q <= 1'b0;
      periph_divide_q <= 2'h0;
      even_n_q <= 4'h0;
      even_src_main_q <= 1'b0;
    end
    else if (wr_en && clock_write_unlock_q)
    begin
      if (address == `OFS_SYS_CLK_CTRL)
      begin
        clkpin_select_q <= {wb[`BIT_CLKPIN_HI], wb[`BIT_CLKPIN_LO]};
        wait_periph_clock_stop_q <= wb[`BIT_WAIT_PSTOP];
        main_osc_stop_q <= wb[`BIT_MAIN_OSC_STOP];
      end
      if (address == `OFS_PERIPH_CLK_CTRL)
      begin
        periph_divide_q <= wb[1:0];
        even_n_q <= wb[5:2];
        even_src_main_q <= wb[`BIT_EVEN_SRC_MAIN];
      end
    end
  end

  // Divider register needs its own unlock; order of changes is software's duty.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      base_divide_q <= 2'h0;
      pbus_divide_q <= 2'h0;
      clock_source_select_q <= 1'b0;
    end
    else if (wr_en && address == `OFS_CLK_DIV_CTRL && divider_write_unlock_q)
    begin
      base_divide_q <= wb[1:0];
      pbus_divide_q <= wb[3:2];
      clock_source_select_q <= wb[`BIT_BCS];
    end
  end

  // Unprotected control bits.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      osc_stop_detect_enable_q <= 1'b0;
      low_speed_select_q <= 2'h0;
      pll_free_run_q <= 1'b0;
      low_voltage_detect_enable_q <= 1'b0;
      keep_sub_in_stop_q <= 1'b0;
      iio_route_q <= 3'h0;
    end
    else if (wr_en)
      case (address)
        `OFS_OSC_CTRL: osc_stop_detect_enable_q <= wb[`BIT_DETECT_EN];
        `OFS_LOW_SPEED_CTRL: low_speed_select_q <= wb[1:0];
        `OFS_PLL_CTRL_ONE: pll_free_run_q <= wb[0];
        `OFS_LVD_CTRL: low_voltage_detect_enable_q <= wb[0];
        `OFS_POWER_CTRL:
        begin
          keep_sub_in_stop_q <= wb[`BIT_KEEP_SUB];
          iio_route_q <= wb[7:5];
        end
        default: iio_route_q <= iio_route_q;
      endcase
  end

  // The stop flag sets while the main clock is stopped; a set beats a same-cycle clear.
  assign osc_stopped = !main_osc_running;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pll_osc_stop_flag_q <= 1'b0;
    else if (osc_stopped)
      pll_osc_stop_flag_q <= 1'b1;
    else if (wr_en && address == `OFS_OSC_CTRL && !wb[`BIT_OSC_STOP_FLAG])
      pll_osc_stop_flag_q <= 1'b0;
  end

  // Self-oscillation status counts PLL cycles, restarts on the free-run set, holds when stopped.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pll_free_run_prev_q <= 1'b0;
      pll_status_q <= '0;
    end
    else
    begin
      pll_free_run_prev_q <= pll_free_run_q;
      if (pll_free_run_q && !pll_free_run_prev_q)
        pll_status_q <= '0;
      else if (main_osc_running && pll_running)
        pll_status_q <= pll_status_q + 16'h0001;
    end
  end

  // Power mode state machine.
  power_mode_fsm u_fsm (
    .clk(clk), .sys_rst(sys_rst), .enter_wait(cmd_wait), .enter_stop(cmd_stop),
    .src(wake_in), .lvd_enable(low_voltage_detect_enable_q), .iio_route(iio_route_q),
    .state(state)
  );
  assign is_normal = (state == PWR_NORMAL);
  assign is_wait = (state == PWR_WAIT);
  assign is_stop = (state == PWR_STOP);

  // Run gates: peripheral-source clocks stop in wait only when asked, always in stop.
  assign psrc_run = is_normal || (is_wait && !wait_periph_clock_stop_q);
  assign even_run = even_src_main_q ? !is_stop : psrc_run;
  assign sub_run = !is_stop || keep_sub_in_stop_q;

  // The base source is untouched by wait, so the CPU resumes on the same clock.
  assign low_speed_tick = (low_speed_select_q == 2'h0) ? sub_clock_tick : onchip_low_tick;
  assign base_src_tick = clock_source_select_q ? low_speed_tick : 1'b1;
  assign even_ratio = {3'h0, even_n_q, 1'b0};

  // Divider chain for every derived clock.
  tick_divider #(.W(8)) u_base (
    .clk(clk), .sys_rst(sys_rst), .tick_in(base_src_tick),
    .ratio({6'h0, base_divide_q} + 8'h01), .run(is_normal), .tick_out(base_tick)
  );
  tick_divider #(.W(8)) u_pbus (
    .clk(clk), .sys_rst(sys_rst), .tick_in(base_tick),
    .ratio({6'h0, pbus_divide_q} + 8'h01), .run(is_normal), .tick_out(pbus_tick)
  );
  tick_divider #(.W(8)) u_psrc (
    .clk(clk), .sys_rst(sys_rst), .tick_in(1'b1),
    .ratio({6'h0, periph_divide_q} + 8'h01), .run(psrc_run), .tick_out(psrc_tick)
  );
  tick_divider #(.W(8)) u_div8 (
    .clk(clk), .sys_rst(sys_rst), .tick_in(psrc_tick),
    .ratio(`RATIO_DIV8), .run(psrc_run), .tick_out(div8_tick)
  );
  tick_divider #(.W(8)) u_div32 (
    .clk(clk), .sys_rst(sys_rst), .tick_in(psrc_tick),
    .ratio(`RATIO_DIV32), .run(psrc_run), .tick_out(div32_tick)
  );
  tick_divider #(.W(8)) u_even (
    .clk(clk), .sys_rst(sys_rst), .tick_in(even_src_main_q ? 1'b1 : psrc_tick),
    .ratio(even_ratio), .run(even_run), .tick_out(even_tick)
  );
  tick_divider #(.W(8)) u_sub32 (
    .clk(clk), .sys_rst(sys_rst), .tick_in(sub_clock_tick),
    .ratio(`RATIO_DIV32), .run(sub_run), .tick_out(sub32_tick)
  );

  // Registered enables; the converter clock follows the undivided peripheral source.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ticks_q <= '0;
    else
    begin
      ticks_q.cpu <= base_tick;
      ticks_q.periph_bus <= pbus_tick;
      ticks_q.periph_clock_div1 <= psrc_tick;
      ticks_q.periph_clock_div8 <= div8_tick;
      ticks_q.periph_clock_div32 <= div32_tick;
      ticks_q.converter_clock <= psrc_tick;
      ticks_q.even_divided_periph_clock <= even_tick;
      ticks_q.sub_clock_div32 <= sub32_tick;
    end
  end

  // Clock pin toggles on the chosen pulse, so its rate is half the pulse rate.
  always_comb
  begin
    case (clkpin_select_q)
      `CLKPIN_LOW_SPEED: clkpin_tick = low_speed_tick;
      `CLKPIN_DIV8: clkpin_tick = div8_tick;
      `CLKPIN_DIV32: clkpin_tick = div32_tick;
      default: clkpin_tick = 1'b0;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || clkpin_select_q == `CLKPIN_OFF)
      clock_output_pin_q <= 1'b0;
    else if (clkpin_tick)
      clock_output_pin_q <= !clock_output_pin_q;
  end
  assign clock_output_pin = clock_output_pin_q;

  // Status and enable outputs, all registered.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      main_osc_enable <= 1'b0;
      pll_free_run_out <= 1'b0;
      osc_stop_detected <= 1'b0;
      low_voltage_detect_on <= 1'b0;
      wait_mode <= 1'b0;
      stop_mode <= 1'b0;
    end
    else
    begin
      main_osc_enable <= !main_osc_stop_q && !is_stop;
      pll_free_run_out <= pll_free_run_q;
      osc_stop_detected <= osc_stop_detect_enable_q && osc_stopped;
      low_voltage_detect_on <= low_voltage_detect_enable_q;
      wait_mode <= is_wait;
      stop_mode <= is_stop;
    end
  end
endmodule // clock_power_ctrl

// >>> test/clock_power_ctrl_assertions.sv
// Concurrent checks for the clock and power block, bound to its top module.
// Assumes a single clock domain and the constants header on the include path.
`timescale 1ns/1ps
`include "clk_power_consts.svh"
module clock_power_ctrl_checker
  import clk_power_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // Oscillator, wake sources and derived outputs.
  input wire logic main_osc_running,
  input wire wake_src_t wake_in,
  input wire clk_ticks_t ticks_q,
  input wire logic main_osc_enable,
  input wire logic pll_free_run_out,
  input wire logic osc_stop_detected,
  input wire logic low_voltage_detect_on,
  input wire logic wait_mode,
  input wire logic stop_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // A write lands at the answer edge, so qualify it with waitrequest low.
  wire logic wr_done = write && !waitrequest && byteenable[0];

  bus_answer_a:
    assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("register access not answered in one cycle");
  mode_excl_a:
    assert property (!(wait_mode && stop_mode))
    else $error("wait and stop shown together");
  osc_cause_a:
    assert property (osc_stop_detected |-> !$past(main_osc_running))
    else $error("oscillator stop reported while main clock ran");
  wait_enter_a:
    assert property (wr_done && address == `OFS_POWER_CTRL && writedata[1:0] == 2'h1 |-> ##2 wait_mode)
    else $error("wait command did not reach wait mode");
  stop_enter_a:
    assert property (wr_done && address == `OFS_POWER_CTRL && writedata[1] |-> ##2 stop_mode)
    else $error("stop command did not reach stop mode");
  stop_halt_a:
    assert property (stop_mode && $past(stop_mode) |-> !ticks_q.cpu && !ticks_q.periph_bus
      && !ticks_q.periph_clock_div1 && !ticks_q.converter_clock && !main_osc_enable)
    else $error("clock still running in stop mode");
  wait_cpu_a:
    assert property (wait_mode && $past(wait_mode) |-> !ticks_q.cpu)
    else $error("cpu clock running in wait mode");
  wait_exit_a:
    assert property (wait_mode && (wake_in.nmi || |wake_in.periph_irq) |-> ##[1:2] !wait_mode)
    else $error("wait mode not left on wake source");
  stop_exit_a:
    assert property (stop_mode && (wake_in.nmi || |wake_in.periph_irq
      || wake_in.lvd_irq && low_voltage_detect_on) |-> ##[1:2] !stop_mode)
    else $error("stop mode not left on wake source");
  lvd_copy_a:
    assert property (wr_done && address == `OFS_LVD_CTRL
      |-> ##2 low_voltage_detect_on == $past(writedata[0], 2))
    else $error("detector enable does not follow its bit");
  free_run_a:
    assert property (wr_done && address == `OFS_PLL_CTRL_ONE
      |-> ##2 pll_free_run_out == $past(writedata[0], 2))
    else $error("free run output does not follow its bit");
endmodule // clock_power_ctrl_checker

bind clock_power_ctrl clock_power_ctrl_checker u_chk (.clk, .sys_rst, .address, .read, .write,
  .writedata, .byteenable, .waitrequest, .main_osc_running, .wake_in, .ticks_q,
  .main_osc_enable, .pll_free_run_out, .osc_stop_detected, .low_voltage_detect_on,
  .wait_mode, .stop_mode);

// >>> test/clock_and_power_mode_control_test.sv
// Self-checking bench for the clock and power block, one task per scenario.
// Assumes the package, header and bound checker are compiled before it.
`timescale 1ns/1ps
module clock_and_power_mode_control_test
  import clk_power_pkg::*;
;
  `include "clk_power_consts.svh"
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic main_osc_running = 1'b1;
  logic pll_running = 1'b1;
  logic sub_clock_tick = 1'b0;
  logic onchip_low_tick = 1'b0;
  wake_src_t wake_in = '0;
  logic [31:0] readdata, rd, v;
  logic waitrequest, clock_output_pin, main_osc_enable, pll_free_run_out, pin_prev;
  logic osc_stop_detected, low_voltage_detect_on, wait_mode, stop_mode;
  clk_ticks_t ticks_q;
  int mismatches = 0, checks = 0;
  int cyc = 0;
  int cnt[9] = '{default: 0};
  int snap[9];
  int d[9];

  clock_power_ctrl u_dut (.clk, .sys_rst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .main_osc_running, .pll_running, .sub_clock_tick,
    .onchip_low_tick, .wake_in, .ticks_q, .clock_output_pin, .main_osc_enable,
    .pll_free_run_out, .osc_stop_detected, .low_voltage_detect_on, .wait_mode, .stop_mode);

  // The 4 ns clock.
  initial
  begin
    forever #2 clk = ~clk;
  end

  // Running tallies of pulses (index = bit of ticks_q) and pin toggles, read by difference.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 8; i++)
      cnt[i] <= cnt[i] + ticks_q[i];
    cnt[8] <= cnt[8] + (clock_output_pin != pin_prev);
    pin_prev <= clock_output_pin;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Counts are bench integers; an exact count is a range of one.
  task automatic chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // Request held until the edge that samples waitrequest low; read data taken there.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    @(posedge clk);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic win(input int n);
    repeat (2) @(posedge clk);
    snap = cnt;
    repeat (n) @(posedge clk);
    foreach (d[i]) d[i] = cnt[i] - snap[i];
  endtask

  task automatic t_reset();
    for (int a = 0; a < 48; a += 4)
      if (a != 'h18)
        rchk(6'(a), (a == 'h28) ? 32'h1 : 32'h0);
    $display("test reset values finished");
  endtask

  task automatic t_protect();
    bus(1'b1, `OFS_CLK_DIV_CTRL, 32'h05);
    rchk(`OFS_CLK_DIV_CTRL, 32'h0);
    bus(1'b1, `OFS_PROTECT_CTRL_TWO, 32'h80);
    bus(1'b1, `OFS_CLK_DIV_CTRL, 32'h01);
    rchk(`OFS_CLK_DIV_CTRL, 32'h01);
    bus(1'b1, `OFS_CLK_DIV_CTRL, 32'h00);
    bus(1'b1, `OFS_PERIPH_CLK_CTRL, 32'h40);
    rchk(`OFS_PERIPH_CLK_CTRL, 32'h0);
    bus(1'b1, `OFS_PROTECT_CTRL, 32'h01);
    bus(1'b1, `OFS_PERIPH_CLK_CTRL, 32'h40);
    rchk(`OFS_PERIPH_CLK_CTRL, 32'h40);
    $display("test write protection finished");
  endtask

  // Pin off, low speed, div8, div32, then the on-chip low clock as the low speed one.
  task automatic t_pin();
    int lo[5] = '{0, 16, 8, 2, 8};
    int hi[5] = '{0, 16, 10, 3, 8};
    for (int i = 0; i < 5; i++)
    begin
      if (i == 4)
        bus(1'b1, `OFS_LOW_SPEED_CTRL, 32'h1);
      bus(1'b1, `OFS_SYS_CLK_CTRL, (i == 4) ? 32'h1 : 32'(i));
      snap = cnt;
      for (int k = 0; k < 64; k++)
      begin
        @(posedge clk);
        sub_clock_tick <= (k % 4 == 0);
        onchip_low_tick <= (k % 8 == 0);
      end
      @(posedge clk);
      sub_clock_tick <= 1'b0;
      onchip_low_tick <= 1'b0;
      repeat (8) @(posedge clk);
      chk_rng(cnt[8] - snap[8], lo[i], hi[i]);
    end
    $display("test clock output pin finished");
  endtask

  task automatic t_osc();
    main_osc_running <= 1'b0;
    repeat (4) @(posedge clk);
    chk_bit(osc_stop_detected, 1'b0);
    rchk(`OFS_OSC_CTRL, 32'h2);
    bus(1'b1, `OFS_OSC_CTRL, 32'h1);
    rchk(`OFS_OSC_CTRL, 32'h3);
    chk_bit(osc_stop_detected, 1'b1);
    main_osc_running <= 1'b1;
    bus(1'b1, `OFS_OSC_CTRL, 32'h1);
    rchk(`OFS_OSC_CTRL, 32'h1);
    chk_bit(osc_stop_detected, 1'b0);
    bus(1'b1, `OFS_SYS_CLK_CTRL, 32'h20);
    repeat (3) @(posedge clk);
    chk_bit(main_osc_enable, 1'b0);
    bus(1'b1, `OFS_SYS_CLK_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk_bit(main_osc_enable, 1'b1);
    $display("test oscillator stop finished");
  endtask

  // Back-to-back reads are three cycles apart, so a running counter advances by three.
  task automatic t_pll();
    bus(1'b1, `OFS_PLL_CTRL_ONE, 32'h1);
    bus(1'b0, `OFS_PLL_STATUS, 32'h0);
    v = rd;
    chk(v, 32'h0);
    bus(1'b0, `OFS_PLL_STATUS, 32'h0);
    chk(rd - v, 32'h3);
    chk_bit(pll_free_run_out, 1'b1);
    pll_running <= 1'b0;
    bus(1'b0, `OFS_PLL_STATUS, 32'h0);
    v = rd;
    bus(1'b0, `OFS_PLL_STATUS, 32'h0);
    chk(rd, v);
    pll_running <= 1'b1;
    $display("test pll status finished");
  endtask

  task automatic t_wait();
    bus(1'b1, `OFS_SYS_CLK_CTRL, 32'h4);
    bus(1'b1, `OFS_POWER_CTRL, 32'h1);
    win(16);
    chk_bit(wait_mode, 1'b1);
    chk_rng(d[5], 0, 0);
    chk_rng(d[1], 1, 16);
    wake_in.periph_irq[5] <= 1'b1;
    repeat (3) @(posedge clk);
    wake_in.periph_irq[5] <= 1'b0;
    chk_bit(wait_mode, 1'b0);
    rchk(`OFS_POWER_CTRL, 32'h1);
    win(8);
    chk_rng(d[7], 7, 8);
    bus(1'b1, `OFS_SYS_CLK_CTRL, 32'h0);
    wake_in.ext_irq_six_to_eight <= 3'h7;
    bus(1'b1, `OFS_POWER_CTRL, 32'h1);
    win(16);
    chk_rng(d[5], 1, 16);
    wake_in.ext_irq_six_to_eight <= 3'h0;
    repeat (4) @(posedge clk);
    chk_bit(wait_mode, 1'b1);
    wake_in.nmi <= 1'b1;
    repeat (3) @(posedge clk);
    wake_in.nmi <= 1'b0;
    chk_bit(wait_mode, 1'b0);
    wake_in.ext_irq_six_to_eight <= 3'h7;
    bus(1'b1, `OFS_POWER_CTRL, 32'h21);
    repeat (2) @(posedge clk);
    wake_in.ext_irq_six_to_eight <= 3'h6;
    repeat (4) @(posedge clk);
    chk_bit(wait_mode, 1'b0);
    $display("test wait mode finished");
  endtask

  task automatic t_stop();
    bus(1'b1, `OFS_LVD_CTRL, 32'h1);
    bus(1'b1, `OFS_POWER_CTRL, 32'h3);
    win(16);
    chk_bit(stop_mode, 1'b1);
    chk_rng(d[7] + d[5] + d[1], 0, 0);
    wake_in.lvd_irq <= 1'b1;
    repeat (3) @(posedge clk);
    wake_in.lvd_irq <= 1'b0;
    chk_bit(stop_mode, 1'b0);
    bus(1'b1, `OFS_LVD_CTRL, 32'h0);
    bus(1'b1, `OFS_POWER_CTRL, 32'h2);
    wake_in.lvd_irq <= 1'b1;
    repeat (4) @(posedge clk);
    chk_bit(stop_mode, 1'b1);
    wake_in.lvd_irq <= 1'b0;
    wake_in.periph_irq[63] <= 1'b1;
    repeat (3) @(posedge clk);
    wake_in.periph_irq[63] <= 1'b0;
    chk_bit(stop_mode, 1'b0);
    $display("test stop mode finished");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reset for twelve cycles, then the scenarios in order.
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_protect();
    t_pin();
    t_osc();
    t_pll();
    t_wait();
    t_stop();
    close_out();
  end
endmodule // clock_and_power_mode_control_test
